// *** design/psfm_pkg.sv ***
// constants and types for the source fault monitor
package psfm_pkg;
  // ----------------------------------------
  // clock and times
  // ----------------------------------------
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1_000;
  localparam int unsigned TEMP_DEB_US    = 10_000;
  localparam int unsigned CC_DEB_US      = 100;
  localparam int unsigned VCONN_DEB_US   = 500;
  localparam int unsigned RESTART_MS     = 2_000;
  localparam int unsigned TEMP_DEB_CYC   = TEMP_DEB_US * CYC_PER_US;
  localparam int unsigned CC_DEB_CYC     = CC_DEB_US * CYC_PER_US;
  localparam int unsigned VCONN_DEB_CYC  = VCONN_DEB_US * CYC_PER_US;
  localparam int unsigned RESTART_CYC    = RESTART_MS * CYC_PER_MS;
  localparam int unsigned CNT_W          = 26;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [4:0] ADDR_CTRL  = 5'h00;
  localparam logic [4:0] ADDR_ICURR = 5'h04;
  localparam logic [4:0] ADDR_TEXT  = 5'h08;
  localparam logic [4:0] ADDR_TDIE  = 5'h0C;
  localparam logic [4:0] ADDR_STAT  = 5'h10;
  localparam logic [4:0] ADDR_MEAS  = 5'h14;
  localparam logic [4:0] ADDR_TMEAS = 5'h18;
  localparam int unsigned CTRL_PPS   = 0;
  localparam int unsigned CTRL_THERM = 1;
  localparam int unsigned CTRL_CABLE = 2;
  localparam int unsigned STAT_OCPH  = 1;
  localparam int unsigned STAT_OTPH  = 2;
  localparam int unsigned HI_LSB     = 16;
  localparam logic [2:0] CTRL_RST      = 3'h0;
  localparam logic [9:0] ICURR_RST     = 10'h12C;
  localparam logic [9:0] EXT_WARN_RST  = 10'h2A0;
  localparam logic [9:0] EXT_OTP_RST   = 10'h2D0;
  localparam logic [9:0] DIE_WARN_RST  = 10'h2B0;
  localparam logic [9:0] DIE_OTP_RST   = 10'h2E0;
  localparam logic [9:0] VBUS_OFF_CODE = 10'h0C8;
  // over-current at 120 percent: iload*5 > limit*6
  localparam logic [12:0] OCP_MUL_I = 13'h0005;
  localparam logic [12:0] OCP_MUL_L = 13'h0006;
  // ----------------------------------------
  // debounce channels
  // ----------------------------------------
  localparam int unsigned NDEB     = 6;
  localparam int unsigned DB_EWARN = 0;
  localparam int unsigned DB_EOTP  = 1;
  localparam int unsigned DB_DWARN = 2;
  localparam int unsigned DB_DOTP  = 3;
  localparam int unsigned DB_CC    = 4;
  localparam int unsigned DB_VCONN = 5;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_FAULT = 3'b010,
    ST_WAIT  = 3'b100
  } psfm_state_e;
  typedef struct packed {
    logic [9:0] vout;
    logic [9:0] iload;
    logic [9:0] temp_ext;
    logic       current_limit_mode;
    logic       ocp_hist;
    logic       otp_hist;
    logic       cable_limited;
  } psfm_status_s;
  typedef struct packed {
    logic over_current_fault;
    logic otp;
    logic temp_warn;
    logic mode_change;
  } psfm_alert_s;
  typedef struct packed {
    logic over_current_fault;
    logic uv;
    logic ext_otp;
    logic die_otp;
    logic cc_ov;
    logic vconn_oc;
  } psfm_fault_s;
endpackage

// *** design/psfm_monitor.sv ***
// source fault monitor with avalon register slave
// How it works
// - fixed contract trips over-current fault above 120 percent of requested current
// - faults except vconn drop pull-up and vbus, then restart at 5 V after delay
// - after over-current, alert on next explicit contract; status keeps the history
// - programmable contract uses current limiting, never the over-current fault
// - programmable contract flags undervoltage only below the vbus off level
// - a new requested current is applied as the new limit at once
// - every change between current limit and constant voltage sends an alert
// - programmable status carries mode flag, output voltage and load current
// - thermistor variant puts external temperature into status
// - external temperature over warning for debounce time sends warning alert
// - external temperature over trip for debounce time raises fault
// - after temperature fault, alert on next explicit contract
// - without thermistor, die temperature warning sends warning alert
// - die temperature over trip for debounce time raises fault
// - with thermistor both trips fault, but warnings come only from thermistor
// - either cc pin over-voltage for debounce time raises fault
// - cable variant sources vconn and discovers cable before advertising 5A
// - vconn over-current for debounce time cuts vconn and aborts discovery
// - after vconn abort advertise 3 A, no alert, set cable limited bit
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module psfm_monitor #(
  parameter int unsigned TEMP_DEB_CYC  = psfm_pkg::TEMP_DEB_CYC,
  parameter int unsigned VCONN_DEB_CYC = psfm_pkg::VCONN_DEB_CYC,
  parameter int unsigned RESTART_CYC   = psfm_pkg::RESTART_CYC
) (
  // clock, reset, enable
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   ce_i,
  // avalon slave
  input  wire logic [4:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output var  logic [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // adc results, same clock
  input  wire logic [9:0]             vout_adc_i,
  input  wire logic [9:0]             iload_adc_i,
  input  wire logic [9:0]             temp_ext_adc_i,
  input  wire logic [9:0]             temp_die_adc_i,
  // comparator pins
  input  wire logic                   cc1_ov_i,
  input  wire logic                   cc2_ov_i,
  input  wire logic                   vconn_oc_i,
  // pd engine
  input  wire logic                   contract_est_i,
  input  wire logic                   disc_done_i,
  input  wire logic                   emarker_5a_i,
  // power path
  output logic                        cc_pullup_en_o,
  output logic                        vbus_switch_en_o,
  output var  logic                   restart_5v_o,
  output logic                        cl_en_o,
  output var  logic [9:0]             cl_limit_o,
  output var  logic                   vconn_en_o,
  output var  logic                   disc_abort_o,
  output logic                        adv_5a_o,
  // reports to sink
  output var  logic                   alert_valid_o,
  output var  psfm_pkg::psfm_alert_s  alert_o,
  output var  psfm_pkg::psfm_status_s status_o
);
  import psfm_pkg::*;

  function automatic logic [9:0] hi10(input logic [31:0] w);
    hi10 = w[HI_LSB +: 10];
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else if (ce_i) begin
      pin_s1 <= {vconn_oc_i, cc2_ov_i, cc1_ov_i};
      pin_s2 <= pin_s1;
    end
  end

  // ----------------------------------------
  // registers and bus
  // ----------------------------------------
  logic [2:0]  ctrl;
  logic [9:0]  ext_warn, ext_otp, die_warn, die_otp;
  logic        ack;
  logic [2:0]  next_ctrl;
  logic [9:0]  next_cl_limit, next_ext_warn, next_ext_otp, next_die_warn, next_die_otp;
  logic [31:0] next_rdata;
  logic        wr_go;
  logic        req;
  logic [31:0] stat_word;
  psfm_fault_s fault_src;
  psfm_state_e state;
  logic        ocp_hist, otp_hist, cable_limited, cl_mode;
  logic        clr_ocph, clr_otph;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign wr_go = avs_write_i & ack;
  assign clr_ocph = wr_go && avs_address_i == ADDR_STAT && avs_writedata_i[STAT_OCPH];
  assign clr_otph = wr_go && avs_address_i == ADDR_STAT && avs_writedata_i[STAT_OTPH];
  assign stat_word = {18'h0, fault_src, 2'h0, (state != ST_RUN), adv_5a_o,
                      cable_limited, otp_hist, ocp_hist, cl_mode};

  always_comb begin
    next_ctrl     = ctrl;
    next_cl_limit = cl_limit_o;
    next_ext_warn = ext_warn;
    next_ext_otp  = ext_otp;
    next_die_warn = die_warn;
    next_die_otp  = die_otp;
    next_rdata    = avs_readdata_o;
    if (wr_go && avs_byteenable_i[0]) begin
      unique case (avs_address_i)
        ADDR_CTRL:  next_ctrl = avs_writedata_i[2:0];
        ADDR_TEXT:  next_ext_warn = avs_writedata_i[9:0];
        ADDR_TDIE:  next_die_warn = avs_writedata_i[9:0];
        ADDR_ICURR: next_cl_limit = avs_writedata_i[9:0];
        default: ;
      endcase
    end
    if (wr_go && avs_byteenable_i[2]) begin
      if (avs_address_i == ADDR_TEXT) next_ext_otp = hi10(avs_writedata_i);
      if (avs_address_i == ADDR_TDIE) next_die_otp = hi10(avs_writedata_i);
    end
    // read data is latched as the wait state ends; unmapped reads give zero
    if (avs_read_i && !ack) begin
      unique case (avs_address_i)
        ADDR_CTRL:  next_rdata = {29'h0, ctrl};
        ADDR_ICURR: next_rdata = {22'h0, cl_limit_o};
        ADDR_TEXT:  next_rdata = {6'h0, ext_otp, 6'h0, ext_warn};
        ADDR_TDIE:  next_rdata = {6'h0, die_otp, 6'h0, die_warn};
        ADDR_STAT:  next_rdata = stat_word;
        ADDR_MEAS:  next_rdata = {6'h0, iload_adc_i, 6'h0, vout_adc_i};
        ADDR_TMEAS: next_rdata = {6'h0, temp_die_adc_i, 6'h0, temp_ext_adc_i};
        default:    next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack            <= 1'b0;
      ctrl           <= CTRL_RST;
      cl_limit_o     <= ICURR_RST;
      ext_warn       <= EXT_WARN_RST;
      ext_otp        <= EXT_OTP_RST;
      die_warn       <= DIE_WARN_RST;
      die_otp        <= DIE_OTP_RST;
      avs_readdata_o <= 32'h0;
    end else if (ce_i) begin
      ack            <= req & ~ack;
      ctrl           <= next_ctrl;
      cl_limit_o     <= next_cl_limit;
      ext_warn       <= next_ext_warn;
      ext_otp        <= next_ext_otp;
      die_warn       <= next_die_warn;
      die_otp        <= next_die_otp;
      avs_readdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // debounce timers
  // ----------------------------------------
  logic [CNT_W-1:0] cnt [NDEB];
  logic [CNT_W-1:0] next_cnt [NDEB];
  logic [CNT_W-1:0] lim [NDEB];
  logic [NDEB-1:0]  cond, deb;
  logic             pps, therm, cable_var, run, disc_active;

  assign pps       = ctrl[CTRL_PPS];
  assign therm     = ctrl[CTRL_THERM];
  assign cable_var = ctrl[CTRL_CABLE];
  assign run       = state == ST_RUN;
  assign lim[DB_EWARN] = CNT_W'(TEMP_DEB_CYC);
  assign lim[DB_EOTP]  = CNT_W'(TEMP_DEB_CYC);
  assign lim[DB_DWARN] = CNT_W'(TEMP_DEB_CYC);
  assign lim[DB_DOTP]  = CNT_W'(TEMP_DEB_CYC);
  assign lim[DB_CC]    = CNT_W'(CC_DEB_CYC);
  assign lim[DB_VCONN] = CNT_W'(VCONN_DEB_CYC);
  assign cond[DB_EWARN] = temp_ext_adc_i > ext_warn;
  assign cond[DB_EOTP]  = temp_ext_adc_i > ext_otp;
  assign cond[DB_DWARN] = temp_die_adc_i > die_warn;
  assign cond[DB_DOTP]  = temp_die_adc_i > die_otp;
  assign cond[DB_CC]    = pin_s2[0] | pin_s2[1];
  assign cond[DB_VCONN] = pin_s2[2] & disc_active;

  always_comb begin
    for (int i = 0; i < NDEB; i++) begin
      deb[i] = cnt[i] == lim[i];
      // counts only while held, any gap restarts
      next_cnt[i] = !cond[i] ? '0 : (deb[i] ? cnt[i] : cnt[i] + 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NDEB; i++) cnt[i] <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < NDEB; i++) cnt[i] <= next_cnt[i];
    end
  end

  // ----------------------------------------
  // fault sequencing
  // ----------------------------------------
  psfm_state_e      next_state;
  psfm_fault_s      cur, next_fault_src;
  logic [CNT_W-1:0] wcnt, next_wcnt;
  logic             present, trip, next_restart;
  logic [12:0]      i_scaled, l_scaled;

  assign i_scaled = 13'(iload_adc_i) * OCP_MUL_I;
  assign l_scaled = 13'(cl_limit_o) * OCP_MUL_L;
  assign cur.over_current_fault      = !pps && i_scaled > l_scaled;
  assign cur.uv       = vout_adc_i < VBUS_OFF_CODE;
  assign cur.ext_otp  = therm & deb[DB_EOTP];
  assign cur.die_otp  = deb[DB_DOTP];
  assign cur.cc_ov    = deb[DB_CC];
  assign cur.vconn_oc = deb[DB_VCONN] & disc_active;
  // vconn trouble stays out of the shutdown path
  assign trip    = cur.over_current_fault | cur.uv | cur.ext_otp | cur.die_otp | cur.cc_ov;
  // undervoltage is ignored while off, vbus is low by design then
  assign present = cur.ext_otp | cur.die_otp | cur.cc_ov;

  always_comb begin
    next_state     = state;
    next_wcnt      = '0;
    next_restart   = 1'b0;
    next_fault_src = fault_src;
    unique case (state)
      ST_RUN: begin
        if (trip) begin
          next_state     = ST_FAULT;
          next_fault_src = cur;
        end
        next_fault_src.vconn_oc = fault_src.vconn_oc | cur.vconn_oc;
      end
      ST_FAULT: begin
        if (!present) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        next_wcnt = wcnt + 1'b1;
        if (present) begin
          next_state = ST_FAULT;
        end else if (wcnt == CNT_W'(RESTART_CYC - 1)) begin
          next_state     = ST_RUN;
          next_restart   = 1'b1;
          next_fault_src = '0;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= ST_RUN;
      wcnt         <= '0;
      restart_5v_o <= 1'b0;
      fault_src    <= '0;
    end else if (ce_i) begin
      state        <= next_state;
      wcnt         <= next_wcnt;
      restart_5v_o <= next_restart;
      fault_src    <= next_fault_src;
    end
  end

  assign cc_pullup_en_o   = state[0];
  assign vbus_switch_en_o = state[0];
  assign cl_en_o          = pps;

  // ----------------------------------------
  // alerts, histories, cable discovery
  // ----------------------------------------
  logic ocp_pend, otp_pend, warn_seen, disc_tried, cable_5a;
  logic next_ocp_pend, next_otp_pend, next_ocp_hist, next_otp_hist, next_cl_mode;
  logic next_disc_active, next_disc_tried, next_cable_5a, next_cable_limited;
  logic warn_now, cl_now, new_otp, send_ct, next_alert_valid;
  psfm_alert_s  next_alert;
  psfm_status_s next_status;

  assign warn_now = therm ? deb[DB_EWARN] : deb[DB_DWARN];
  assign cl_now   = pps && run && iload_adc_i >= cl_limit_o;
  assign new_otp  = run && (cur.ext_otp | cur.die_otp);
  assign send_ct  = contract_est_i && run;
  assign adv_5a_o = cable_var && cable_5a && !cable_limited;

  always_comb begin
    next_ocp_pend = (ocp_pend & ~send_ct) | (run & cur.over_current_fault);
    next_otp_pend = (otp_pend & ~send_ct) | new_otp;
    // a new event wins over a software clear
    next_ocp_hist = (ocp_hist & ~clr_ocph) | (run & cur.over_current_fault);
    next_otp_hist = (otp_hist & ~clr_otph) | new_otp;
    next_cl_mode  = cl_now;
    next_alert.over_current_fault         = send_ct & ocp_pend;
    next_alert.otp         = send_ct & otp_pend;
    next_alert.temp_warn   = warn_now & ~warn_seen;
    next_alert.mode_change = pps & (cl_now != cl_mode);
    next_alert_valid = |next_alert;
    next_disc_active = disc_active & run; // vconn must not outlive a disconnect
    next_disc_tried  = disc_tried & ~restart_5v_o;
    next_cable_5a    = cable_5a;
    next_cable_limited = cable_limited;
    if (cable_var && run && !disc_tried && !disc_active) begin
      next_disc_active = 1'b1;
      next_disc_tried  = 1'b1;
      next_cable_5a    = 1'b0;
    end
    if (disc_active && cur.vconn_oc) begin
      next_disc_active   = 1'b0;
      next_cable_limited = 1'b1;
    end else if (disc_active && disc_done_i) begin
      next_disc_active = 1'b0;
      next_cable_5a    = emarker_5a_i;
    end
    next_status.vout               = vout_adc_i;
    next_status.iload              = iload_adc_i;
    next_status.temp_ext           = therm ? temp_ext_adc_i : 10'h000;
    next_status.current_limit_mode = cl_now;
    next_status.ocp_hist           = next_ocp_hist;
    next_status.otp_hist           = next_otp_hist;
    next_status.cable_limited      = next_cable_limited;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ocp_pend      <= 1'b0;
      otp_pend      <= 1'b0;
      ocp_hist      <= 1'b0;
      otp_hist      <= 1'b0;
      cl_mode       <= 1'b0;
      warn_seen     <= 1'b0;
      alert_valid_o <= 1'b0;
      alert_o       <= '0;
      disc_active   <= 1'b0;
      disc_tried    <= 1'b0;
      cable_5a      <= 1'b0;
      cable_limited <= 1'b0;
      vconn_en_o    <= 1'b0;
      disc_abort_o  <= 1'b0;
      status_o      <= '0;
    end else if (ce_i) begin
      ocp_pend      <= next_ocp_pend;
      otp_pend      <= next_otp_pend;
      ocp_hist      <= next_ocp_hist;
      otp_hist      <= next_otp_hist;
      cl_mode       <= next_cl_mode;
      warn_seen     <= warn_now;
      alert_valid_o <= next_alert_valid;
      alert_o       <= next_alert;
      disc_active   <= next_disc_active;
      disc_tried    <= next_disc_tried;
      cable_5a      <= next_cable_5a;
      cable_limited <= next_cable_limited;
      vconn_en_o    <= next_disc_active;
      disc_abort_o  <= disc_active & cur.vconn_oc;
      status_o      <= next_status;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_ocp_trip: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && run && !pps && i_scaled > l_scaled |=> state == ST_FAULT && !vbus_switch_en_o)
    else $error("over-current did not shut the output");
  chk_restart_5v: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(restart_5v_o) |-> cc_pullup_en_o && $past(state) == ST_WAIT)
    else $error("restart without wait state");
  chk_ocp_alert: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && send_ct && ocp_pend |=> alert_valid_o && alert_o.over_current_fault)
    else $error("over-current alert missing on contract");
  chk_pps_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && pps && run && iload_adc_i >= cl_limit_o |=> status_o.current_limit_mode)
    else $error("limit mode not reported");
  chk_uv_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(fault_src.uv) |-> $past(vout_adc_i) < VBUS_OFF_CODE)
    else $error("undervoltage above off level");
  chk_limit_apply: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_go && avs_address_i == ADDR_ICURR && avs_byteenable_i[0]
      |=> cl_limit_o == $past(avs_writedata_i[9:0]))
    else $error("new current limit not applied");
  chk_mode_alert: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && pps && cl_now != cl_mode |=> alert_valid_o && alert_o.mode_change)
    else $error("mode change without alert");
  chk_deb_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !cond[DB_CC] |=> cnt[DB_CC] == '0)
    else $error("cc debounce not restarted");
  chk_cc_fault: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && run && deb[DB_CC] |=> state == ST_FAULT ##1 !cc_pullup_en_o)
    else $error("cc over-voltage not acted on");
  chk_vconn_abort: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && disc_active && cur.vconn_oc |=> !vconn_en_o && disc_abort_o && cable_limited && run)
    else $error("vconn abort incomplete");
endmodule
`default_nettype wire

// *** bench/psfm_sink_model.sv ***
// sink model on the far side of the power path
`timescale 1ns/1ns
`default_nettype none
module psfm_sink_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // from the source
  input  wire logic       vbus_on_i,
  input  wire logic [9:0] demand_i,
  // to the source
  output logic [9:0]      vout_o,
  output logic [9:0]      iload_o,
  output logic            contract_o
);
  logic [2:0] cnt;
  // no vbus means no voltage and no load
  assign vout_o     = vbus_on_i ? 10'h1F4 : 10'h000;
  assign iload_o    = vbus_on_i ? demand_i : 10'h000;
  assign contract_o = (cnt == 3'h5);
  // negotiation ends a few cycles after vbus returns, once only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt <= 3'h0;
    else if (!vbus_on_i) cnt <= 3'h0;
    else if (cnt != 3'h7) cnt <= cnt + 3'h1;
  end
endmodule
`default_nettype wire

// *** bench/pd_source_fault_monitor_test.sv ***
// self-checking bench for the source fault monitor
`timescale 1ns/1ns
`default_nettype none
module pd_source_fault_monitor_test;
  import psfm_pkg::*;
  logic        clk_i, rst_b_i, rd, wr, cc1, cc2, voc, cest, done, e5;
  logic        wreq, pull, vbus, r5, cl, vc, dab, a5, av;
  logic [4:0]  adr;
  logic [31:0] wd, rdat, q;
  logic [9:0]  vout, il, dem, te, td, lim;
  logic [5:0]  acc;
  psfm_alert_s  al;
  psfm_status_s st;
  int          err_total, num_checks, wdc;
  psfm_monitor #(.TEMP_DEB_CYC(8), .VCONN_DEB_CYC(6), .RESTART_CYC(10)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .vout_adc_i(vout), .iload_adc_i(il), .temp_ext_adc_i(te),
    .temp_die_adc_i(td), .cc1_ov_i(cc1), .cc2_ov_i(cc2), .vconn_oc_i(voc),
    .contract_est_i(cest), .disc_done_i(done), .emarker_5a_i(e5), .cc_pullup_en_o(pull),
    .vbus_switch_en_o(vbus), .restart_5v_o(r5), .cl_en_o(cl), .cl_limit_o(lim),
    .vconn_en_o(vc), .disc_abort_o(dab), .adv_5a_o(a5), .alert_valid_o(av), .alert_o(al),
    .status_o(st));
  psfm_sink_model sink_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .vbus_on_i(vbus),
    .demand_i(dem), .vout_o(vout), .iload_o(il), .contract_o(cest));
  // ----
  // clock, watchdog, pulse catcher
  // ----
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    wdc <= wdc + 1;
    if (wdc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // one-cycle pulses are caught off the active edge
  always @(negedge clk_i) acc <= acc | {r5, dab, (av === 1'b1) ? al : 4'h0};
  // ----
  // tasks
  // ----
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk_i); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // bounded wait for the port to reconnect
  task automatic reconn;
    for (int i = 0; i < 60 && pull !== 1'b1; i++) @(posedge clk_i);
    chk(pull, 1'b1);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {rst_b_i, rd, wr, cc1, cc2, voc, done, e5} = 8'h01;
    {adr, wd, acc, wdc, err_total, num_checks} = '0;
    dem = 10'h064;
    te = 10'h100;
    td = 10'h100;
    cyc(20);
    rst_b_i <= 1'b1;
    cyc(1);
    chk(pull, 1'b1);
    bus(0, ADDR_ICURR, 0); chk(q, {22'h0, ICURR_RST});
    bus(0, ADDR_TEXT, 0); chk(q, 32'h02D0_02A0);
    bus(0, 5'h1C, 0); chk(q, 0);
    // exactly 120 percent holds, one code more trips
    dem <= 10'h168; cyc(6); chk(pull, 1'b1);
    dem <= 10'h169; cyc(4); chk({pull, vbus}, 0);
    dem <= 10'h064; acc <= '0; reconn(); cyc(10);
    chk(acc[5], 1'b1); chk(acc[3], 1'b1);
    bus(0, ADDR_STAT, 0); chk(q[STAT_OCPH], 1'b1);
    acc <= '0; bus(1, ADDR_CTRL, 1); bus(1, ADDR_ICURR, 32'h64);
    chk(lim, 10'h064); chk(cl, 1'b1);
    dem <= 10'h0C8; cyc(6); chk(pull, 1'b1); chk(acc[0], 1'b1);
    chk(st.current_limit_mode, 1'b1); chk(st.iload, 10'h0C8);
    acc <= '0; dem <= 10'h032; cyc(6); chk(acc[0], 1'b1);
    // a short excursion must not count toward the warning
    acc <= '0; bus(1, ADDR_CTRL, 2); te <= 10'h2A1; cyc(6);
    te <= 10'h200; cyc(2); chk(acc[1], 1'b0);
    te <= 10'h2A1; cyc(12); chk(acc[1], 1'b1); chk(st.temp_ext, 10'h2A1);
    acc <= '0; te <= 10'h200; td <= 10'h2B1; cyc(12); chk(acc[1], 1'b0);
    td <= 10'h100; acc <= '0; te <= 10'h2D1; cyc(12); chk(pull, 1'b0);
    te <= 10'h100; reconn(); cyc(10); chk(acc[2], 1'b1);
    acc <= '0; bus(1, ADDR_CTRL, 4); td <= 10'h2B1; cyc(12); chk(acc[1], 1'b1);
    td <= 10'h2E1; cyc(12); chk(pull, 1'b0); td <= 10'h100; reconn();
    cc2 <= 1'b1; cyc(2520); chk(pull, 1'b0); cc2 <= 1'b0; reconn();
    cyc(2); chk(vc, 1'b1);
    acc <= '0; voc <= 1'b1; cyc(12); chk(vc, 1'b0); chk(acc[4], 1'b1);
    chk(acc[3:0], 0); chk(a5, 1'b0); chk(pull, 1'b1);
    bus(0, ADDR_STAT, 0); chk(q[3], 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
